// file: dv/mstep_chk.sv
// port checker of the indexer: stepping, direction, homing, bridge outputs
// assumes the bind at the foot attaches it to every mstep_indexer
`timescale 1ns/10ps
`default_nettype none

module mstep_chk (
  input wire logic       ref_clk,            // system clock
  input wire logic       reset,              // async reset
  input wire logic       clk_en,             // run enable
  input wire logic       advance_pin,        // step pin
  input wire logic       rotation_sense_pin, // direction pin
  input wire logic       uvlo_active,        // undervoltage level
  input wire logic       sleep_active,       // sleep level
  input wire logic [9:0] angle_ff,           // angle
  input wire logic [7:0] winding_a_current,  // A target
  input wire logic [7:0] winding_b_current,  // B target
  input wire logic       bridge_a_fwd_ff,    // A polarity
  input wire logic       bridge_a_drive_ff,  // A on
  input wire logic [6:0] bridge_a_level_ff,  // A level
  input wire logic       bridge_b_fwd_ff,    // B polarity
  input wire logic       bridge_b_drive_ff,  // B on
  input wire logic [6:0] bridge_b_level_ff,  // B level
  input wire logic       step_done_ff,       // step pulse
  input wire logic       at_home_ff          // home flag
);
  // magnitudes of the signed targets, for the bridge checks
  wire logic [7:0] mag_a = winding_a_current[7] ? 8'h00 - winding_a_current
                                                 : winding_a_current;
  wire logic [7:0] mag_b = winding_b_current[7] ? 8'h00 - winding_b_current
                                                 : winding_b_current;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  step_moves_a:
    assert property (step_done_ff |-> $changed(angle_ff))
    else $error("step pulse left the angle unchanged");
  move_cause_a:
    assert property ($changed(angle_ff) |-> step_done_ff || angle_ff == 10'h080)
    else $error("angle moved without a step or homing");
  step_lat_a:
    assert property (step_done_ff |-> $past(advance_pin, 3) && !$past(advance_pin, 4))
    else $error("step pulse not tied to an advance rise");
  dir_up_a:
    assert property (step_done_ff && $past(rotation_sense_pin, 2)
                     |-> angle_ff - $past(angle_ff) < 10'h200)
    else $error("sense high but angle went down");
  dir_down_a:
    assert property (step_done_ff && !$past(rotation_sense_pin, 2)
                     |-> $past(angle_ff) - angle_ff < 10'h200)
    else $error("sense low but angle went up");
  home_flag_a:
    assert property (at_home_ff == (angle_ff == 10'h080))
    else $error("home flag disagrees with angle");
  home_hold_a:
    assert property ((uvlo_active || sleep_active) [*3] |-> angle_ff == 10'h080)
    else $error("angle not held at home");
  bridge_a_a:
    assert property (bridge_a_fwd_ff == !winding_a_current[7] && {1'b0, bridge_a_level_ff} == mag_a
                     && bridge_a_drive_ff == (winding_a_current != 8'h00))
    else $error("bridge A disagrees with its target");
  bridge_b_a:
    assert property (bridge_b_fwd_ff == !winding_b_current[7] && {1'b0, bridge_b_level_ff} == mag_b
                     && bridge_b_drive_ff == (winding_b_current != 8'h00))
    else $error("bridge B disagrees with its target");

  // main scenarios reached
  cover property (step_done_ff && $past(rotation_sense_pin, 2));
  cover property (step_done_ff && !$past(rotation_sense_pin, 2));
  cover property ($fell(uvlo_active));
  cover property ($fell(sleep_active));
endmodule

bind mstep_indexer mstep_chk chk (
  .ref_clk, .reset, .clk_en, .advance_pin, .rotation_sense_pin,
  .uvlo_active, .sleep_active, .angle_ff, .winding_a_current,
  .winding_b_current, .bridge_a_fwd_ff, .bridge_a_drive_ff,
  .bridge_a_level_ff, .bridge_b_fwd_ff, .bridge_b_drive_ff,
  .bridge_b_level_ff, .step_done_ff, .at_home_ff
);
`default_nettype wire

// file: dv/mstep_ctrl_model.sv
// motion controller model: one advance pulse per request, sense steady
// assumes go is a one-cycle request raised only while busy is low
`timescale 1ns/10ps
`default_nettype none

module mstep_ctrl_model (
  input  wire logic ref_clk,            // system clock
  input  wire logic go,                 // start one pulse
  input  wire logic dir,                // direction for it
  input  wire logic slow,               // stretch high phase
  output var  logic advance_pin,        // step pin
  output var  logic rotation_sense_pin, // direction pin
  output var  logic busy                // pulse in progress
);
  int cnt;
  int len;

  initial begin
    advance_pin = 1'b0;
    rotation_sense_pin = 1'b0;
    busy = 1'b0;
    cnt = 0;
    len = 4;
  end

  // sense moves only at a request, well before the rise and long after
  // the fall, so the indexer never samples it near an edge
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      rotation_sense_pin <= dir;
      len <= slow ? 12 : 4;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      advance_pin <= cnt >= 3 && cnt < 3 + len;
      busy <= cnt < len + 8;
    end
  end
endmodule
`default_nettype wire

// file: dv/mstep_indexer_test.sv
// bench: steps the indexer in every mode, mode changes, hold, homing
// assumes mstep_ctrl_model drives the pins and mstep_chk is bound
`timescale 1ns/10ps
`default_nettype none

module mstep_indexer_test;
  logic       ref_clk = 1'b0;   // 8 ns clock
  logic       reset = 1'b1;     // async reset
  logic [3:0] step_mode = 4'h3; // mode field
  logic       uvlo = 1'b0;      // undervoltage level
  logic       sleep = 1'b0;     // sleep level
  logic       go = 1'b0;        // pulse request
  logic       dir = 1'b1;       // pulse direction
  logic       slow = 1'b0;      // long pulse
  wire logic       adv, sense, busy;
  wire logic [9:0] angle;
  wire logic [7:0] cur_a, cur_b;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 19;
  int ang = 128;  // model angle
  int armed = 0;  // model: hold armed on entering full step
  int m, k;
  int tbl [9] = '{0, 20, 38, 56, 71, 83, 92, 98, 100};

  initial forever #4 ref_clk = ~ref_clk;

  mstep_indexer dut (
    .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .advance_pin(adv),
    .rotation_sense_pin(sense), .step_mode(step_mode), .uvlo_active(uvlo),
    .sleep_active(sleep), .angle_ff(angle), .winding_a_current(cur_a),
    .winding_b_current(cur_b), .bridge_a_fwd_ff(), .bridge_a_drive_ff(),
    .bridge_a_level_ff(), .bridge_b_fwd_ff(), .bridge_b_drive_ff(),
    .bridge_b_level_ff(), .step_done_ff(), .at_home_ff());

  mstep_ctrl_model ctrl (
    .ref_clk(ref_clk), .go(go), .dir(dir), .slow(slow), .advance_pin(adv),
    .rotation_sense_pin(sense), .busy(busy));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a run still going at 30000 cycles ends as a failure
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic cmp_angle(input logic [9:0] exp);
    comparisons++;
    if (angle !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, angle, exp);
    end
  endtask

  task automatic cmp_cur(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // signed percent at eighth-step index i; full 100% and non-circular half force 100
  function automatic int sn(input int i, input int md);
    int v;
    v = ((i / 8) % 2) ? tbl[8 - i % 8] : tbl[i % 8];
    if ((md == 0 || md == 2) && v != 0)
      v = 100;
    return ((i / 8) % 4 > 1) ? -v : v;
  endfunction

  // currents are compared only at eighth-step points: finer ones are interpolated
  task automatic check_all();
    @(negedge ref_clk);
    cmp_angle(10'(ang));
    if (ang % 32 == 0) begin
      cmp_cur(cur_a, 8'(sn(ang / 32, step_mode)));
      cmp_cur(cur_b, 8'(sn((ang / 32 + 8) % 32, step_mode)));
    end
  endtask

  task automatic set_mode(input int md);
    @(posedge ref_clk);
    if (step_mode >= 2 && md < 2)
      armed = 1;
    if (md >= 2)
      armed = 0;
    step_mode <= 4'(md);
    // let the new code land before the step model reads it
    @(posedge ref_clk);
  endtask

  // model one step, then let the controller make the pulse
  task automatic pulse(input int d);
    int md, inc, off, rel, fl, n;
    md = step_mode;
    inc = 1 << (md < 2 ? 8 : md < 4 ? 7 : 10 - md);
    off = md < 2 ? 128 : 0;
    rel = (ang - off) & 1023;
    fl = rel & ~(inc - 1);
    if (uvlo || sleep)
      ang = 128;
    else if (armed && d == 0 && (ang & 255) == 128)
      ang = ang;
    else if (d != 0)
      ang = (off + fl + inc) & 1023;
    else
      ang = (off + (rel == fl ? rel - inc : fl)) & 1023;
    armed = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    dir <= 1'(d);
    slow <= 1'($random(seed) & 1);
    @(posedge ref_clk);
    go <= 1'b0;
    for (n = 0; n < 60 && (busy || n < 2); n++)
      @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    check_all();
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_angle(10'h080);
    cmp_cur(cur_a, 8'h00);
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check_all();
    $display("test reset done");
    for (m = 0; m < 11; m++) begin
      set_mode(m);
      for (k = 0; k < 8; k++)
        pulse(1);
      pulse(0);
    end
    $display("test mode sweep done");
    for (k = 0; k < 40; k++) begin
      set_mode(($random(seed) & 32'h7FFF) % 11);
      pulse($random(seed) & 1);
    end
    $display("test random modes done");
    set_mode(4);
    for (k = 0; k < 16 && (ang & 255) != 128; k++)
      pulse(1);
    set_mode(0);
    pulse(0);
    pulse(0);
    $display("test full step hold done");
    set_mode(3);
    for (k = 0; k < 2; k++) begin
      pulse(1);
      @(posedge ref_clk);
      uvlo <= k == 0;
      sleep <= k == 1;
      // the model reads the homing levels, so let them land first
      @(posedge ref_clk);
      pulse(1);
      @(posedge ref_clk);
      uvlo <= 1'b0;
      sleep <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check_all();
    end
    $display("test homing done");
    final_report();
  end
endmodule
`default_nettype wire

// file: hw/mstep_indexer.v
// microstep indexer: advance/rotation-sense pins to per-winding targets
// assumes step_mode comes from logic on ref_clk (no synchroniser);
// uvlo_active and sleep_active are on-chip levels on ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "mstep_map.vh"

// Operation
// - codes 0/1/2 give full step 100%, full step 71%, non-circular half.
// - code 3 half step, codes 4..10 each halve increment down to 1/256.
// - each rising advance edge moves exactly one table state, save the held edge below and edges under lockout or sleep.
// - sense high steps angle up, low steps down; controller holds it steady.
// - after a mode change the next edge lands on the new mode's grid.
// - micro to full with sense low on full angle: first edge holds.
// - home angle 45 degrees after reset, undervoltage exit, sleep exit.
// - winding A target is sine of angle, B is cosine, signed percent.
// - positive drives terminal one to terminal two, negative reverses.
// - full 71% mode cycles 45/135/225/315 degrees at 71% magnitude.
// - half step eight states from 0 degrees; quarter 16, eighth 32.
// - eighth step quadrant levels 0..100; finer modes subdivide same wave.
// - two independent bridges, each with its own signed target.
// - full 100% mode cycles the four diagonals at plus or minus 100%.
// - non-circular half: eight states, each winding 0 or plus/minus 100%.
module mstep_indexer (
  input  wire       ref_clk,            // 125 MHz system clock
  input  wire       reset,              // async reset, active high
  input  wire       clk_en,             // freeze all state when low
  input  wire       advance_pin,        // step pulse pin, async
  input  wire       rotation_sense_pin, // direction pin, async
  input  wire [3:0] step_mode,          // step mode field
  input  wire       uvlo_active,        // logic undervoltage lockout
  input  wire       sleep_active,       // low-power sleep state
  output reg  [9:0] angle_ff,           // electrical angle, 1024/cycle
  output reg  [7:0] winding_a_current,  // signed percent, sine
  output reg  [7:0] winding_b_current,  // signed percent, cosine
  output reg        bridge_a_fwd_ff,    // A: terminal one to two
  output reg        bridge_a_drive_ff,  // A: nonzero target
  output reg  [6:0] bridge_a_level_ff,  // A: magnitude percent
  output reg        bridge_b_fwd_ff,    // B: terminal one to two
  output reg        bridge_b_drive_ff,  // B: nonzero target
  output reg  [6:0] bridge_b_level_ff,  // B: magnitude percent
  output reg        step_done_ff,       // pulse: angle step taken
  output reg        at_home_ff          // angle sits on home
);

  // pin synchroniser outputs
  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire       adv_rise;
  wire       sense_up;

  // mode decode
  reg        full_mode;
  reg        micro_mode;
  reg  [3:0] inc_shift;
  reg  [9:0] inc;
  reg  [9:0] base;

  // next-angle arithmetic
  reg  [9:0] rel;
  reg  [9:0] aligned;
  reg        on_grid;
  reg        on_full_angle;
  reg  [9:0] nxt_angle;
  reg        nxt_hold;
  reg        nxt_step;

  // state
  reg  [3:0] mode_ff;
  reg        hold_ff;
  wire       homing;

  // table lookup stage
  reg  [9:0] angle_b;
  reg  [8:0] idx_a;
  reg  [8:0] idx_b;
  reg        neg_a;
  reg        neg_b;
  reg  [2:0] frac_a_ff;
  reg  [2:0] frac_b_ff;
  reg        neg_a_ff;
  reg        neg_b_ff;
  reg        force_ff;
  wire [6:0] lo_a;
  wire [6:0] hi_a;
  wire [6:0] lo_b;
  wire [6:0] hi_b;

  // interpolation
  reg  [9:0] prod_a;
  reg  [9:0] prod_b;
  reg  [6:0] mag_a;
  reg  [6:0] mag_b;
  reg  [7:0] nxt_cur_a;
  reg  [7:0] nxt_cur_b;

  // both pins pass two flops; equal delay keeps sense aligned to edge
  mstep_sync #(
    .W (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .pin_in  ({rotation_sense_pin, advance_pin}),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  assign adv_rise = pin_rise[0];
  assign sense_up = pin_level[1];
  assign homing   = uvlo_active | sleep_active;

  // mode to increment; unused codes above 1/256 step as 1/256
  always @* begin
    full_mode  = (step_mode == `MSTEP_MODE_FULL100) |
                 (step_mode == `MSTEP_MODE_FULL71);
    micro_mode = ~((mode_ff == `MSTEP_MODE_FULL100) |
                   (mode_ff == `MSTEP_MODE_FULL71));
    if (full_mode) begin
      inc_shift = `MSTEP_SHIFT_FULL;
    end else if (step_mode <= `MSTEP_MODE_HALF) begin
      inc_shift = `MSTEP_SHIFT_HALF;
    end else if (step_mode <= `MSTEP_MODE_FINEST) begin
      inc_shift = `MSTEP_SHIFT_BASE - step_mode;
    end else begin
      inc_shift = 4'h0;
    end
    inc  = `MSTEP_ANGLE_ONE << inc_shift;
    // full-step grid sits on the diagonals, the rest on zero
    base = full_mode ? `MSTEP_FULL_OFFSET : `MSTEP_ANGLE_ZERO;
  end

  // next valid state of the active mode in the sensed direction
  always @* begin
    rel           = angle_ff - base;
    aligned       = rel & ~(inc - `MSTEP_ANGLE_ONE);
    on_grid       = (rel == aligned);
    on_full_angle = ({2'b00, angle_ff[7:0]} == `MSTEP_FULL_OFFSET);
    nxt_angle     = angle_ff;
    nxt_hold      = hold_ff;
    nxt_step      = 1'b0;
    if (full_mode && micro_mode) begin
      nxt_hold = 1'b1;
    end else if (!full_mode) begin
      nxt_hold = 1'b0;
    end
    if (adv_rise) begin
      nxt_hold = 1'b0;
      if (full_mode && micro_mode) begin
        // mode switched in this very cycle: keep the hold disarmed, this edge is the one checked
        nxt_hold = 1'b0;
      end
      if ((hold_ff || (full_mode && micro_mode)) && full_mode &&
          !sense_up && on_full_angle) begin
        nxt_angle = angle_ff;
      end else if (sense_up) begin
        nxt_angle = base + aligned + inc;
        nxt_step  = 1'b1;
      end else if (on_grid) begin
        nxt_angle = base + aligned - inc;
        nxt_step  = 1'b1;
      end else begin
        nxt_angle = base + aligned;
        nxt_step  = 1'b1;
      end
    end
  end

  // angle counter; lockout and sleep hold it at home
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      angle_ff     <= `MSTEP_HOME_ANGLE;
      mode_ff      <= `MSTEP_MODE_FULL100;
      hold_ff      <= 1'b0;
      step_done_ff <= 1'b0;
      at_home_ff   <= 1'b1;
    end else if (clk_en) begin
      mode_ff <= step_mode;
      if (homing) begin
        angle_ff     <= `MSTEP_HOME_ANGLE;
        hold_ff      <= 1'b0;
        step_done_ff <= 1'b0;
        at_home_ff   <= 1'b1;
      end else begin
        angle_ff     <= nxt_angle;
        hold_ff      <= nxt_hold;
        step_done_ff <= nxt_step && (nxt_angle != angle_ff);
        at_home_ff   <= (nxt_angle == `MSTEP_HOME_ANGLE);
      end
    end
  end

  // fold angle into a quarter-wave index; cosine is sine plus 90 deg
  always @* begin
    angle_b = angle_ff + `MSTEP_QUARTER;
    if (angle_ff[8]) begin
      idx_a = 9'h100 - {1'b0, angle_ff[7:0]};
    end else begin
      idx_a = {1'b0, angle_ff[7:0]};
    end
    if (angle_b[8]) begin
      idx_b = 9'h100 - {1'b0, angle_b[7:0]};
    end else begin
      idx_b = {1'b0, angle_b[7:0]};
    end
    neg_a = angle_ff[9];
    neg_b = angle_b[9];
  end

  // one table per winding so the bridges never share a read slot
  mstep_sine_rom u_rom_a (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .addr    (idx_a[8:3]),
    .data_lo (lo_a),
    .data_hi (hi_a)
  );

  mstep_sine_rom u_rom_b (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .addr    (idx_b[8:3]),
    .data_lo (lo_b),
    .data_hi (hi_b)
  );

  // side data that travels with the table read
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frac_a_ff <= 3'h0;
      frac_b_ff <= 3'h0;
      neg_a_ff  <= 1'b0;
      neg_b_ff  <= 1'b0;
      force_ff  <= 1'b0;
    end else if (clk_en) begin
      frac_a_ff <= idx_a[2:0];
      frac_b_ff <= idx_b[2:0];
      neg_a_ff  <= neg_a;
      neg_b_ff  <= neg_b;
      force_ff  <= (mode_ff == `MSTEP_MODE_FULL100) |
                   (mode_ff == `MSTEP_MODE_NCHALF);
    end
  end

  // linear fill between coarse points; exact on 1/32 grid and coarser
  always @* begin
    prod_a = {3'h0, hi_a - lo_a} * {7'h00, frac_a_ff};
    prod_b = {3'h0, hi_b - lo_b} * {7'h00, frac_b_ff};
    prod_a = prod_a + 10'h004;
    prod_b = prod_b + 10'h004;
    mag_a  = lo_a + prod_a[9:3];
    mag_b  = lo_b + prod_b[9:3];
    // square-wave modes: any nonzero level becomes full scale
    if (force_ff && (mag_a != `MSTEP_PCT_ZERO)) begin
      mag_a = `MSTEP_PCT_FULL;
    end
    if (force_ff && (mag_b != `MSTEP_PCT_ZERO)) begin
      mag_b = `MSTEP_PCT_FULL;
    end
    // zero never carries a sign
    if (neg_a_ff && (mag_a != `MSTEP_PCT_ZERO)) begin
      nxt_cur_a = ~{1'b0, mag_a} + 8'h01;
    end else begin
      nxt_cur_a = {1'b0, mag_a};
    end
    if (neg_b_ff && (mag_b != `MSTEP_PCT_ZERO)) begin
      nxt_cur_b = ~{1'b0, mag_b} + 8'h01;
    end else begin
      nxt_cur_b = {1'b0, mag_b};
    end
  end

  // registered targets and per-bridge polarity
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      winding_a_current <= `MSTEP_RST_CURRENT;
      winding_b_current <= `MSTEP_RST_CURRENT;
      bridge_a_fwd_ff   <= 1'b1;
      bridge_a_drive_ff <= 1'b0;
      bridge_a_level_ff <= `MSTEP_RST_LEVEL;
      bridge_b_fwd_ff   <= 1'b1;
      bridge_b_drive_ff <= 1'b0;
      bridge_b_level_ff <= `MSTEP_RST_LEVEL;
    end else if (clk_en) begin
      winding_a_current <= nxt_cur_a;
      winding_b_current <= nxt_cur_b;
      bridge_a_fwd_ff   <= ~nxt_cur_a[7];
      bridge_a_drive_ff <= (mag_a != `MSTEP_PCT_ZERO);
      bridge_a_level_ff <= mag_a;
      bridge_b_fwd_ff   <= ~nxt_cur_b[7];
      bridge_b_drive_ff <= (mag_b != `MSTEP_PCT_ZERO);
      bridge_b_level_ff <= mag_b;
    end
  end

endmodule
`default_nettype wire

// file: hw/mstep_map.vh
// constants of the microstep indexer: mode codes, angle grid, levels
// assumes a 10-bit angle of 1024 positions per electrical cycle
`ifndef MSTEP_MAP_VH
`define MSTEP_MAP_VH

// step mode codes
`define MSTEP_MODE_FULL100 4'h0
`define MSTEP_MODE_FULL71  4'h1
`define MSTEP_MODE_NCHALF  4'h2
`define MSTEP_MODE_HALF    4'h3
`define MSTEP_MODE_FINEST  4'hA

// angle grid, 1024 positions = 360 degrees
`define MSTEP_HOME_ANGLE   10'h080
`define MSTEP_FULL_OFFSET  10'h080
`define MSTEP_QUARTER      10'h100
`define MSTEP_ANGLE_ONE    10'h001
`define MSTEP_ANGLE_ZERO   10'h000

// increment exponents, increment = 1 << exponent
`define MSTEP_SHIFT_FULL   4'h8
`define MSTEP_SHIFT_HALF   4'h7
`define MSTEP_SHIFT_BASE   4'hA

// current levels in percent of full scale
`define MSTEP_PCT_FULL     7'h64
`define MSTEP_PCT_ZERO     7'h00

// reset values of the outputs
`define MSTEP_RST_CURRENT  8'h00
`define MSTEP_RST_LEVEL    7'h00

`endif

// file: hw/mstep_sine_rom.v
// quarter-wave sine table, 33 points, percent of full scale
// two registered read ports: entry and the entry after it
`timescale 1ns/10ps
`default_nettype none

module mstep_sine_rom (
  input  wire       ref_clk,  // system clock
  input  wire       reset,    // async reset, active high
  input  wire       clk_en,   // freeze when low
  input  wire [5:0] addr,     // coarse index 0..32
  output reg  [6:0] data_lo,  // table at addr
  output reg  [6:0] data_hi   // table at addr+1, clamped
);

  // coarse points every 1/32 step; past the end reads full scale
  function [6:0] pct;
    input [5:0] k;
    begin
      case (k)
        6'h00: pct = 7'h00;
        6'h01: pct = 7'h05;
        6'h02: pct = 7'h0A;
        6'h03: pct = 7'h0F;
        6'h04: pct = 7'h14;
        6'h05: pct = 7'h18;
        6'h06: pct = 7'h1D;
        6'h07: pct = 7'h22;
        6'h08: pct = 7'h26;
        6'h09: pct = 7'h2B;
        6'h0A: pct = 7'h2F;
        6'h0B: pct = 7'h33;
        6'h0C: pct = 7'h38;
        6'h0D: pct = 7'h3C;
        6'h0E: pct = 7'h3F;
        6'h0F: pct = 7'h43;
        6'h10: pct = 7'h47;
        6'h11: pct = 7'h4A;
        6'h12: pct = 7'h4D;
        6'h13: pct = 7'h50;
        6'h14: pct = 7'h53;
        6'h15: pct = 7'h56;
        6'h16: pct = 7'h58;
        6'h17: pct = 7'h5A;
        6'h18: pct = 7'h5C;
        6'h19: pct = 7'h5E;
        6'h1A: pct = 7'h60;
        6'h1B: pct = 7'h61;
        6'h1C: pct = 7'h62;
        6'h1D: pct = 7'h63;
        default: pct = 7'h64;
      endcase
    end
  endfunction

  // registered reads
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      data_lo <= 7'h00;
      data_hi <= 7'h00;
    end else if (clk_en) begin
      data_lo <= pct(addr);
      data_hi <= pct(addr + 6'h01);
    end
  end

endmodule
`default_nettype wire

// file: hw/mstep_sync.v
// two-stage synchroniser with rising edge detect, one lane per pin
// assumes asynchronous pins; clk_en freezes every stage
`timescale 1ns/10ps
`default_nettype none

module mstep_sync #(
  parameter W = 2
) (
  input  wire         ref_clk,  // system clock
  input  wire         reset,    // async reset, active high
  input  wire         clk_en,   // freeze when low
  input  wire [W-1:0] pin_in,   // raw pin levels
  output wire [W-1:0] level,    // synchronised level
  output wire [W-1:0] rise      // one-cycle rising edge
);

  genvar i;

  // per lane: meta stage read only by the sync stage
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg meta_ff;
      reg sync_ff;
      reg last_ff;
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          last_ff <= 1'b0;
        end else if (clk_en) begin
          meta_ff <= pin_in[i];
          sync_ff <= meta_ff;
          last_ff <= sync_ff;
        end
      end
      assign level[i] = sync_ff;
      assign rise[i]  = sync_ff & ~last_ff;
    end
  endgenerate

endmodule
`default_nettype wire
